// file: lcdid_pkg.sv
// Constants for the LCD instruction decoder: codes, fields, widths.
// Assumes a single 100 MHz clock domain.
package lcdid_pkg;
  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] CODE_CHARS = 8'h02;
  localparam logic [7:0] CODE_TDIV = 8'h03;
  localparam logic [7:0] CODE_CROW = 8'h04;
  localparam logic [7:0] CODE_START_LO = 8'h08;
  localparam logic [7:0] CODE_START_HI = 8'h09;
  localparam logic [7:0] CODE_CUR_LO = 8'h0a;
  localparam logic [7:0] CODE_CUR_HI = 8'h0b;
  localparam logic [7:0] CODE_WRITE = 8'h0c;
  localparam logic [7:0] CODE_READ = 8'h0d;
  localparam logic [7:0] CODE_BCLR = 8'h0e;
  localparam logic [7:0] CODE_BSET = 8'h0f;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int BUSY_BIT = 7;
  localparam int CARRY_BIT = 7;
  localparam int ROW_W = 4;
  localparam int BIDX_W = 3;
  localparam int CHAR_ADDR_W = 12;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [6:0] STATUS_PAD = 7'h00;
  // ****************************************
  // Buffer and executor
  // ****************************************
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  typedef enum logic [1:0] {S_IDLE, S_READ, S_MODIFY, S_WRITE} lcdid_state_e;
endpackage

// file: lcdid_decoder.sv
// Instruction decoder of a dot-matrix graphic LCD controller.
// Host bus pins are asynchronous; RAM port and mode inputs share clk.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) Row count stored as value minus one
// (R2) Time-division count stored as count minus one
// (R3) Cursor row stored minus one, bits 3-0
// (R4) Cursor wins over character; hidden past pitch
// (R5) Cursor width equals horizontal pitch
// (R6) Start address; char mode drops top nibble
// (R7) Start address gives top-left fetch location
// (R8) Low-byte bit7 fall increments high byte
// (R9) Host loads low before high byte
// (R10) Cursor address is RAM and cursor location
// (R11) Data write stores, then cursor increments
// (R12) Read returns buffer, refills, increments cursor
// (R13) Host discards first read after load
// (R14) Bit set/clear at cursor, then increment
// (R15) Status read shows busy on bit 7
// (R16) Host waits for busy clear
// (R17) Instruction write leaves busy untouched
// (R18) Busy readable at any time
// (R19) Code byte selects, data byte executes
// (R20) Row count means chars or bytes
// (R21) Unknown codes are ignored entirely
// (R22) Busy from data accept until update done
module lcdid_decoder
  import lcdid_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_enable,
  input wire logic register_select,
  input wire logic host_read,
  input wire logic [7:0] host_bus_lines_in,
  output logic [7:0] host_bus_lines_out,
  output logic host_bus_lines_oe,
  output logic ram_req,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [7:0] ram_rdata,
  input wire logic graphic_mode,
  input wire logic cursor_on,
  input wire logic [3:0] vert_pitch_m1,
  input wire logic [2:0] horiz_pitch_m1,
  output logic [7:0] chars_per_row,
  output logic [7:0] time_division_count,
  output logic [3:0] cursor_row,
  output logic [15:0] display_start,
  output logic [15:0] cursor_address,
  output logic cursor_shown,
  output logic [2:0] cursor_width_m1,
  output logic busy
);
  // ****************************************
  // Host pin synchronisers
  // ****************************************
  logic en_s1_q, en_s2_q, en_s3_q;
  logic rs_s1_q, rs_s2_q, rd_s1_q, rd_s2_q;
  logic [7:0] din_s1_q, din_s2_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      rs_s1_q <= 1'b0;
      rs_s2_q <= 1'b0;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      din_s1_q <= BYTE_RST;
      din_s2_q <= BYTE_RST;
    end else begin
      en_s1_q <= host_enable;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      rs_s1_q <= register_select;
      rs_s2_q <= rs_s1_q;
      rd_s1_q <= host_read;
      rd_s2_q <= rd_s1_q;
      din_s1_q <= host_bus_lines_in;
      din_s2_q <= din_s1_q;
    end
  end

  // ****************************************
  // Strobe decode
  // ****************************************
  // Access completes on the falling enable edge, once pins are settled.
  logic [7:0] code_q;
  wire strobe_end = en_s3_q & ~en_s2_q;
  wire code_wr = strobe_end & rs_s2_q & ~rd_s2_q;
  wire data_wr = strobe_end & ~rs_s2_q & ~rd_s2_q;
  wire data_rd = strobe_end & ~rs_s2_q & rd_s2_q & (code_q == CODE_READ);
  wire code_known = (code_q == CODE_CHARS) | (code_q == CODE_TDIV) |
                    (code_q == CODE_CROW) | (code_q == CODE_START_LO) |
                    (code_q == CODE_START_HI) | (code_q == CODE_CUR_LO) |
                    (code_q == CODE_CUR_HI) | (code_q == CODE_WRITE) |
                    (code_q == CODE_BCLR) | (code_q == CODE_BSET);
  // Unknown codes never enter the buffer, so nothing moves.
  wire push_req = (data_wr & code_known) | data_rd;  // see (R21) see (R19)

  // Instruction byte is latched directly, outside the busy path.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= BYTE_RST;
    end else if (code_wr) begin
      code_q <= din_s2_q;  // see (R17) see (R19)
    end
  end

  // ****************************************
  // Two-entry operation buffer
  // ****************************************
  // A host ignoring busy can overrun it; such a write is dropped.
  logic [7:0] fifo_code [FIFO_DEPTH];
  logic [7:0] fifo_data [FIFO_DEPTH];
  logic fifo_wp_q, fifo_rp_q;
  logic [1:0] fifo_cnt_q;
  lcdid_state_e st_q;
  wire fifo_in_ready = (fifo_cnt_q != FIFO_FULL);
  wire fifo_out_valid = (fifo_cnt_q != FIFO_EMPTY);
  wire fifo_out_ready = (st_q == S_IDLE);
  wire push = push_req & fifo_in_ready;
  wire pop = fifo_out_valid & fifo_out_ready;
  wire [7:0] op_code = fifo_code[fifo_rp_q];
  wire [7:0] op_data = fifo_data[fifo_rp_q];

  always_ff @(posedge clk) begin
    if (push) begin
      fifo_code[fifo_wp_q] <= code_q;
      fifo_data[fifo_wp_q] <= din_s2_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= FIFO_EMPTY;
    end else begin
      fifo_wp_q <= fifo_wp_q ^ push;
      fifo_rp_q <= fifo_rp_q ^ pop;
      if (push & ~pop) begin
        fifo_cnt_q <= fifo_cnt_q + CNT_ONE;
      end else if (pop & ~push) begin
        fifo_cnt_q <= fifo_cnt_q - CNT_ONE;
      end
    end
  end

  // ****************************************
  // Executor
  // ****************************************
  logic [7:0] chars_q, tdiv_q, start_lo_q, start_hi_q, obuf_q, wdata_q;
  logic [3:0] crow_q;
  logic [15:0] cur_q;
  logic [BIDX_W-1:0] bidx_q;
  logic bset_q, req_q, we_q, rd_op_q;

  function automatic logic [7:0] bit_mask(input logic [BIDX_W-1:0] idx);
    bit_mask = BYTE_ONE << idx;
  endfunction

  wire is_ram_op = (op_code == CODE_WRITE) | (op_code == CODE_READ) |
                   (op_code == CODE_BCLR) | (op_code == CODE_BSET);
  wire lo_carry = cur_q[CARRY_BIT] & ~op_data[CARRY_BIT];
  wire [7:0] modified = bset_q ? (ram_rdata | bit_mask(bidx_q))
                               : (ram_rdata & ~bit_mask(bidx_q));
  wire rd_done = (st_q == S_READ) & ram_ack;
  wire wr_done = (st_q == S_WRITE) & ram_ack;
  wire [15:0] cur_inc = cur_q + ADDR_ONE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= BYTE_RST;
      bidx_q <= '0;
      bset_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (pop & is_ram_op) begin
            req_q <= 1'b1;
            we_q <= (op_code == CODE_WRITE);
            wdata_q <= op_data;  // see (R11)
            bidx_q <= op_data[BIDX_W-1:0];  // see (R14)
            bset_q <= (op_code == CODE_BSET);
            st_q <= (op_code == CODE_WRITE) ? S_WRITE : S_READ;
          end
        end
        S_READ: begin
          if (ram_ack) begin
            req_q <= 1'b0;
            // Read data stands only in the ack cycle, so merge it here
            wdata_q <= modified;  // see (R14)
            st_q <= rd_op_q ? S_IDLE : S_MODIFY;  // see (R12)
          end
        end
        S_MODIFY: begin
          req_q <= 1'b1;
          we_q <= 1'b1;
          st_q <= S_WRITE;
        end
        S_WRITE: begin
          if (ram_ack) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Read-op marker kept beside the state so the refill skips modify.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_op_q <= 1'b0;
    end else if (pop) begin
      rd_op_q <= (op_code == CODE_READ);
    end
  end

  // ****************************************
  // Setting registers and cursor counter
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chars_q <= BYTE_RST;
      tdiv_q <= BYTE_RST;
      crow_q <= NIBBLE_ZERO;
      start_lo_q <= BYTE_RST;
      start_hi_q <= BYTE_RST;
      cur_q <= ADDR_RST;
      obuf_q <= BYTE_RST;
    end else begin
      if (pop) begin
        case (op_code)
          CODE_CHARS: chars_q <= op_data;  // see (R1) see (R20)
          CODE_TDIV: tdiv_q <= op_data;  // see (R2)
          CODE_CROW: crow_q <= op_data[ROW_W-1:0];  // see (R3)
          CODE_START_LO: start_lo_q <= op_data;  // see (R6)
          CODE_START_HI: start_hi_q <= op_data;  // see (R6)
          CODE_CUR_LO: begin
            // Counter behaviour: a falling bit 7 ripples into the high byte.
            cur_q[7:0] <= op_data;  // see (R8) see (R9)
            if (lo_carry) begin
              cur_q[15:8] <= cur_q[15:8] + BYTE_ONE;  // see (R8)
            end
          end
          CODE_CUR_HI: cur_q[15:8] <= op_data;  // see (R8)
          default: begin
          end
        endcase
      end
      if (rd_done & rd_op_q) begin
        obuf_q <= ram_rdata;  // see (R12) see (R13)
        cur_q <= cur_inc;  // see (R12)
      end
      if (wr_done) begin
        cur_q <= cur_inc;  // see (R11) see (R14)
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire busy_d = push | fifo_out_valid | (st_q != S_IDLE);  // see (R22)
  wire drive_d = en_s2_q & rd_s2_q;
  wire [7:0] bus_d = rs_s2_q ? {busy, STATUS_PAD} : obuf_q;
  wire [15:0] start_full = {start_hi_q, start_lo_q};
  wire [15:0] start_d = graphic_mode ? start_full :
                        {NIBBLE_ZERO, start_full[CHAR_ADDR_W-1:0]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      host_bus_lines_oe <= 1'b0;
      host_bus_lines_out <= BYTE_RST;
      display_start <= ADDR_RST;
      cursor_shown <= 1'b0;
      cursor_width_m1 <= '0;
    end else begin
      busy <= busy_d;  // see (R22) see (R16)
      host_bus_lines_oe <= drive_d;  // see (R18)
      host_bus_lines_out <= bus_d;  // see (R15) see (R12)
      display_start <= start_d;  // see (R6) see (R7)
      cursor_shown <= cursor_on & (crow_q <= vert_pitch_m1);  // see (R4) see (R10)
      cursor_width_m1 <= horiz_pitch_m1;  // see (R5)
    end
  end

  assign ram_req = req_q;
  assign ram_we = we_q;
  assign ram_addr = cur_q;  // see (R10)
  assign ram_wdata = wdata_q;
  assign chars_per_row = chars_q;
  assign time_division_count = tdiv_q;
  assign cursor_row = crow_q;
  assign cursor_address = cur_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_busy_on_accept: assert property (push |=> busy) else $error("busy not raised"); // see (R22)
  a_low_carry: assert property (pop && op_code == CODE_CUR_LO && lo_carry |=>
    cur_q[15:8] == $past(cur_q[15:8]) + BYTE_ONE) else $error("no carry"); // see (R8)
  a_write_incr: assert property (wr_done |=> cur_q == $past(cur_q) + ADDR_ONE)
    else $error("cursor not incremented"); // see (R11)
  a_status_read: assert property (en_s2_q && rd_s2_q && rs_s2_q |=>
    host_bus_lines_oe && host_bus_lines_out[BUSY_BIT] == $past(busy))
    else $error("status byte wrong"); // see (R15)
  a_ignore_unknown: assert property (data_wr && !code_known && fifo_cnt_q == FIFO_EMPTY
    && st_q == S_IDLE |=> $stable(chars_q) && $stable(cur_q) && !busy)
    else $error("unknown code acted"); // see (R21)
  a_cursor_hidden: assert property (crow_q > vert_pitch_m1 |=> !cursor_shown)
    else $error("cursor shown past pitch"); // see (R4)
  a_start_mask: assert property (!graphic_mode |=> display_start[15:12] == NIBBLE_ZERO)
    else $error("start nibble not masked"); // see (R6)
  a_read_refill: assert property (rd_done && rd_op_q |=> obuf_q == $past(ram_rdata))
    else $error("buffer not refilled"); // see (R12)
  a_code_no_busy: assert property (code_wr && !busy && fifo_cnt_q == FIFO_EMPTY
    && st_q == S_IDLE |=> !busy) else $error("code write set busy"); // see (R17)

  c_data_write: cover property (pop && op_code == CODE_WRITE ##[1:20] wr_done);
  c_bit_set: cover property (pop && op_code == CODE_BSET ##[1:40] wr_done);
  c_data_read: cover property (data_rd ##[1:40] rd_done);
  c_buffer_full: cover property (fifo_cnt_q == FIFO_FULL);
endmodule

`default_nettype wire

// file: lcdid_ram_model.sv
// RAM model on the far side of the decoder's RAM port.
// Assumes one clock shared with the decoder.
`timescale 1ns/1ps
`default_nettype none
module lcdid_ram_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic ram_ack,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:65535];
  logic [4:0] wait_q;
  logic gap_q;
  // Slow mode keeps busy up long enough to be seen
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 5'h00;
      ram_ack <= 1'b0;
      gap_q <= 1'b0;
      ram_rdata <= 8'h00;
    end else begin
      ram_ack <= 1'b0;
      gap_q <= ram_ack;
      // Data is garbage outside the ack cycle
      ram_rdata <= ~ram_rdata;
      if (ram_req && !ram_ack && !gap_q) begin
        wait_q <= wait_q + 5'h01;
        if (wait_q >= (slow ? 5'h14 : 5'h00)) begin
          wait_q <= 5'h00;
          ram_ack <= 1'b1;
          if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
          end else begin
            ram_rdata <= mem[ram_addr];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: lcdid_decoder_tb.sv
// Self-checking bench for the LCD instruction decoder.
// Assumes the package, design and RAM model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lcdid_decoder_tb;
  import lcdid_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_enable = 1'b0;
  logic register_select = 1'b1;
  logic host_read = 1'b1;
  logic [7:0] host_bus_lines_in = 8'h00;
  logic slow = 1'b0;
  logic graphic_mode = 1'b1;
  logic cursor_on = 1'b1;
  logic [3:0] vert_pitch_m1 = 4'h7;
  logic [2:0] horiz_pitch_m1 = 3'h5;
  logic [7:0] host_bus_lines_out, ram_rdata, ram_wdata, chars_per_row, time_division_count;
  logic host_bus_lines_oe, ram_req, ram_we, ram_ack, cursor_shown, busy;
  logic [3:0] cursor_row;
  logic [2:0] cursor_width_m1;
  logic [15:0] ram_addr, display_start, cursor_address;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] seed = 32'h95a9df4b;
  logic [7:0] b, v;
  always #5 clk = ~clk;
  lcdid_decoder dut (.clk, .reset_n, .host_enable, .register_select, .host_read,
    .host_bus_lines_in, .host_bus_lines_out, .host_bus_lines_oe, .ram_req, .ram_we,
    .ram_addr, .ram_wdata, .ram_ack, .ram_rdata, .graphic_mode, .cursor_on,
    .vert_pitch_m1, .horiz_pitch_m1, .chars_per_row, .time_division_count, .cursor_row,
    .display_start, .cursor_address, .cursor_shown, .cursor_width_m1, .busy);
  lcdid_ram_model ram (.clk, .reset_n, .slow, .ram_req, .ram_we, .ram_addr, .ram_wdata,
    .ram_ack, .ram_rdata);
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic shown(logic on, logic [3:0] row, logic [3:0] vp);
    return on && (row <= vp);
  endfunction
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Strobe held 6 cycles each way, twice the sync depth
  task automatic bus(logic sel, logic rdn, logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    register_select = sel;
    host_read = rdn;
    host_bus_lines_in = rdn ? ~host_bus_lines_in : d;
    host_enable = 1'b1;
    repeat (6) @(posedge clk);
    // Sample off the edge that may launch a new value
    #1 q = host_bus_lines_out;
    if (rdn) chk("bus_drive", 1'b1, host_bus_lines_oe);
    host_enable = 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(logic sel, logic [7:0] d);
    logic [7:0] q;
    bus(sel, 1'b0, d, q);
  endtask
  task automatic idle();
    logic [7:0] q;
    for (int i = 0; i < 100; i++) begin
      bus(1'b1, 1'b1, 8'h00, q);
      if (q[BUSY_BIT] === 1'b0) return;
    end
    mismatches++;
    final_report();
  endtask
  task automatic cmd(logic [7:0] c, logic [7:0] d);
    wr(1'b1, c);
    wr(1'b0, d);
    idle();
  endtask
  task automatic setcur(logic [15:0] a);
    cmd(CODE_CUR_LO, a[7:0]);
    cmd(CODE_CUR_HI, a[15:8]);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 1'b1, 8'h00, b);
    chk("status_idle", 1'b0, b[BUSY_BIT]);
    for (int i = 0; i < 6; i++) begin
      b = rnd();
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h7f : {1'b0, b[6:1], 1'b1};
      cmd(CODE_CHARS, v);
      chk("chars_per_row", v, chars_per_row);
      cmd(CODE_TDIV, v ^ 8'h01);
      chk("time_division_count", v ^ 8'h01, time_division_count);
      cmd(CODE_CROW, {4'h0, v[3:0]});
      chk("cursor_row", v[3:0], cursor_row);
      #1 b = rnd();
      vert_pitch_m1 = b[3:0];
      horiz_pitch_m1 = b[6:4];
      cursor_on = b[7] | (i == 0);
      repeat (3) @(posedge clk);
      chk("cursor_shown", shown(cursor_on, v[3:0], b[3:0]), cursor_shown);
      chk("cursor_width", b[6:4], cursor_width_m1);
    end
    v = rnd();
    cmd(CODE_START_LO, v);
    cmd(CODE_START_HI, 8'hc5);
    #1 graphic_mode = 1'b0;
    repeat (3) @(posedge clk);
    chk("start_char", {8'h05, v}, display_start);
    #1 graphic_mode = 1'b1;
    repeat (3) @(posedge clk);
    chk("start_graphic", {8'hc5, v}, display_start);
    setcur(16'h1280);
    cmd(CODE_CUR_LO, 8'h05);
    chk("cursor_carry", 16'h1305, cursor_address);
    cmd(CODE_CUR_HI, 8'h12);
    chk("cursor_high", 16'h1205, cursor_address);
    setcur(16'h12fe);
    wr(1'b1, CODE_WRITE);
    chk("busy_after_code", 1'b0, busy);
    for (int i = 0; i < 4; i++) begin
      #1 slow = i[0];
      v = rnd();
      wr(1'b0, v);
      if (slow) begin
        chk("busy_write", 1'b1, busy);
        bus(1'b1, 1'b1, 8'h00, b);
        chk("status_busy", 1'b1, b[BUSY_BIT]);
      end
      idle();
      chk("ram_write", v, ram.mem[16'h12fe + i]);
      chk("cursor_write", 16'h12ff + i, cursor_address);
    end
    setcur(16'h12fe);
    wr(1'b1, CODE_READ);
    bus(1'b0, 1'b1, 8'h00, b);
    idle();
    for (int i = 0; i < 4; i++) begin
      #1 slow = i[1];
      bus(1'b0, 1'b1, 8'h00, b);
      chk("read_data", ram.mem[16'h12fe + i], b);
      idle();
    end
    chk("cursor_read", 16'h1303, cursor_address);
    for (int i = 0; i < 16; i++) ram.mem[16'h2000 + i] = i[0] ? 8'hff : 8'h00;
    setcur(16'h2000);
    for (int i = 0; i < 8; i++) begin
      cmd(CODE_BSET, i[7:0]);
      cmd(CODE_BCLR, i[7:0]);
      v = 8'h01 << i;
      chk("bit_set", v, ram.mem[16'h2000 + 2 * i]);
      v = ~v;
      chk("bit_clear", v, ram.mem[16'h2001 + 2 * i]);
    end
    chk("cursor_bits", 16'h2010, cursor_address);
    for (int i = 0; i < 3; i++) begin
      v = rnd() | 8'h10;
      wr(1'b1, v);
      wr(1'b0, rnd());
      chk("busy_unknown", 1'b0, busy);
      chk("cursor_unknown", 16'h2010, cursor_address);
    end
    final_report();
  end
endmodule
`default_nettype wire
